// ==== logic/sslat_regs.vh ====
// constants for the serial shift latch driver
`ifndef SSLAT_REGS_VH
`define SSLAT_REGS_VH
`define SSLAT_CHANNELS 12
`define SSLAT_FIFO_WIDTH 1
`define SSLAT_FIFO_DEPTH 32
`define SSLAT_FIFO_AW 5
`define SSLAT_ZERO12 12'h000
`define SSLAT_FIFO_PTR_ONE 5'h01
`define SSLAT_FIFO_CNT_ONE 6'h01
`define SSLAT_FIFO_CNT_ZERO 6'h00
`define SSLAT_FIFO_CNT_FULL 6'h20
`endif

// ==== logic/sslat_fifo.v ====
// small synchronous fifo with valid and ready on both sides
`default_nettype none
module sslat_fifo #(
	parameter WIDTH = 1,
	parameter DEPTH = 32,
	parameter AW    = 5
) (
	input  wire             clk,
	input  wire             rstSyncN,
	input  wire             clrN,
	input  wire [WIDTH-1:0] inData,
	input  wire             inValid,
	output wire             inReady,
	output reg  [WIDTH-1:0] outData,
	output wire             outValid,
	input  wire             outReady
);
`include "sslat_regs.vh"
	// ==========================================
	// storage and pointers
	reg  [WIDTH-1:0] mem [0:DEPTH-1];
	reg  [AW-1:0]    wrPtr_r;
	reg  [AW-1:0]    rdPtr_r;
	reg  [AW:0]      count_r;
	reg              outValid_r;
	wire             push;
	wire             pop;
	wire             haveWord;
	wire             take;

	assign haveWord = (count_r != `SSLAT_FIFO_CNT_ZERO);
	assign inReady  = (count_r != `SSLAT_FIFO_CNT_FULL);
	assign outValid = outValid_r;
	assign push     = inValid && inReady;
	// registered read port: refill when empty or consumed
	assign take     = haveWord && (!outValid_r || outReady);
	assign pop      = take;

	always @(posedge clk)
	begin
		if (push)
			mem[wrPtr_r] <= inData;
		if (take)
			outData <= mem[rdPtr_r];
	end

	always @(posedge clk or negedge rstSyncN)
	begin
		if (!rstSyncN)
		begin
			wrPtr_r    <= {AW{1'b0}};
			rdPtr_r    <= {AW{1'b0}};
			count_r    <= {(AW+1){1'b0}};
			outValid_r <= 1'b0;
		end
		else if (!clrN)
		begin
			wrPtr_r    <= {AW{1'b0}};
			rdPtr_r    <= {AW{1'b0}};
			count_r    <= {(AW+1){1'b0}};
			outValid_r <= 1'b0;
		end
		else
		begin
			if (push)
				wrPtr_r <= wrPtr_r + `SSLAT_FIFO_PTR_ONE;
			if (pop)
				rdPtr_r <= rdPtr_r + `SSLAT_FIFO_PTR_ONE;
			if (push && !pop)
				count_r <= count_r + `SSLAT_FIFO_CNT_ONE;
			else if (pop && !push)
				count_r <= count_r - `SSLAT_FIFO_CNT_ONE;
			if (take)
				outValid_r <= 1'b1;
			else if (outReady)
				outValid_r <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ==== logic/sslat_top.v ====
// twelve channel serial shift register and latch with drain drivers
// Summary of operation
// R1: twelve-stage serial shift register loads a twelve-bit storage latch
// R2: shift on shift clock rise; latch loads on latch clock rise
// R3: latch reaches output buffers only while clear_n is high
// R4: drains change at the latch clock rise that loads new data
// R5: clear_n low resets shift register, latch, fifo and outputs; pin synchronisers and edge history keep running
// R6: host should pulse clear_n low at power-up or initialization
// R7: cascade output updates on the falling edge of shift clock
// R8: output enable high forces every buffer bit low, drains off
// R9: output enable low lets buffers follow the latch directly
// R10: buffer bit high turns its drain on; low leaves it off
// R11: host may pulse output enable for global dimming
// R12: over-temperature forces all outputs open until it clears
// R13: cascade output presents the last shift register stage
// R14: each drain maps one-to-one to one latch bit
`default_nettype none
`include "sslat_regs.vh"
module sslat_top (
	input  wire        clk,
	input  wire        rstn,
	input  wire        shiftClock,
	input  wire        latchClock,
	input  wire        clearN,
	input  wire        shiftDataIn,
	input  wire        outEnableN,
	input  wire        overTemp,
	output reg         cascadeDataOut,
	output reg  [11:0] drainOn,
	output reg         shiftStall
);
	// ==========================================
	// reset release
	reg rstMeta_r;
	reg rstSync_r;

	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rstMeta_r <= 1'b0;
			rstSync_r <= 1'b0;
		end
		else
		begin
			rstMeta_r <= 1'b1;
			rstSync_r <= rstMeta_r;
		end
	end

	// ==========================================
	// link pin synchronisers
	// the link clocks are sampled like data; edges are found below
	reg  [2:0] linkMeta_r;
	reg  [2:0] linkSync_r;
	reg        sckPrev_r;
	reg        lckPrev_r;

	always @(posedge clk or negedge rstSync_r)
	begin
		if (!rstSync_r)
		begin
			linkMeta_r <= 3'h0;
			linkSync_r <= 3'h0;
		end
		else
		begin
			linkMeta_r <= {shiftDataIn, latchClock, shiftClock};
			linkSync_r <= linkMeta_r;
		end
	end

	// ==========================================
	// level pin synchronisers
	reg  [2:0] levelMeta_r;
	reg  [2:0] levelSync_r;

	always @(posedge clk or negedge rstSync_r)
	begin
		if (!rstSync_r)
		begin
			levelMeta_r <= 3'h0;
			levelSync_r <= 3'h0;
		end
		else
		begin
			levelMeta_r <= {overTemp, outEnableN, clearN};
			levelSync_r <= levelMeta_r;
		end
	end

	wire sck    = linkSync_r[0];
	wire lck    = linkSync_r[1];
	wire sdi    = linkSync_r[2];
	wire clrN   = levelSync_r[0];
	wire oeN    = levelSync_r[1];
	wire hot    = levelSync_r[2];
	wire sckUp;
	wire sckDn;
	wire lckUp;

	// ==========================================
	// edge history of the sampled link clocks
	// reset to the idle low level so no false edge follows reset
	always @(posedge clk or negedge rstSync_r)
	begin
		if (!rstSync_r)
		begin
			sckPrev_r <= 1'b0;
			lckPrev_r <= 1'b0;
		end
		else
		begin
			sckPrev_r <= sck;
			lckPrev_r <= lck;
		end
	end

	// ==========================================
	// helpers shared by the edge detectors and the output gate
	function riseOf;
		input cur;
		input prev;
	begin
		riseOf = cur && !prev;
	end
	endfunction

	function fallOf;
		input cur;
		input prev;
	begin
		fallOf = !cur && prev;
	end
	endfunction

	// drains idle whenever output enable is high or the die is hot
	function [11:0] gateDrains;
		input [11:0] stored;
		input        offReq;
		input        tooHot;
	begin
		if (offReq || tooHot)
			gateDrains = `SSLAT_ZERO12;
		else
			gateDrains = stored;
	end
	endfunction

	assign sckUp = riseOf(sck, sckPrev_r); // R2
	assign sckDn = fallOf(sck, sckPrev_r); // R7
	assign lckUp = riseOf(lck, lckPrev_r); // R2

	// ==========================================
	// input fifo between pin sampler and shift chain
	// the fifo decouples sampling from shifting; a stall here means
	// the shift clock outran the chain and a bit would be lost
	wire fifoInReady;
	wire fifoOutValid;
	wire fifoOutData;
	wire fifoOutReady;

	sslat_fifo #(
		.WIDTH (`SSLAT_FIFO_WIDTH),
		.DEPTH (`SSLAT_FIFO_DEPTH),
		.AW    (`SSLAT_FIFO_AW)
	) uFifo (
		.clk      (clk),
		.rstSyncN (rstSync_r),
		.clrN     (clrN),
		.inData   (sdi),
		.inValid  (sckUp),
		.inReady  (fifoInReady),
		.outData  (fifoOutData),
		.outValid (fifoOutValid),
		.outReady (fifoOutReady)
	);

	// ==========================================
	// bits sampled but not yet in the chain
	// the fifo holds a bit between memory and read register, so its
	// valid flag alone can drop for a cycle while a bit is queued
	reg  [5:0] inFlight_r;
	reg  [5:0] inFlight_nxt;
	wire       chainIdle;

	always @*
	begin
		inFlight_nxt = inFlight_r;
		if (sckUp && fifoInReady && !fifoOutValid)
			inFlight_nxt = inFlight_r + `SSLAT_FIFO_CNT_ONE;
		else if (fifoOutValid && !(sckUp && fifoInReady))
			inFlight_nxt = inFlight_r - `SSLAT_FIFO_CNT_ONE;
	end

	always @(posedge clk or negedge rstSync_r)
	begin
		if (!rstSync_r)
			inFlight_r <= `SSLAT_FIFO_CNT_ZERO;
		else if (!clrN)
			inFlight_r <= `SSLAT_FIFO_CNT_ZERO; // R5
		else
			inFlight_r <= inFlight_nxt;
	end

	assign chainIdle = (inFlight_r == `SSLAT_FIFO_CNT_ZERO);

	// ==========================================
	// shift chain and storage latch
	reg  [11:0] shiftReg_r;
	reg  [11:0] shiftReg_nxt;
	reg  [11:0] latch_r;
	reg  [11:0] latch_nxt;
	reg         lastStage_r;
	reg         latchPend_r;
	reg         latchPend_nxt;

	// a latch edge waits for queued bits so it loads what was sent
	wire drainIdle = chainIdle && !fifoOutValid;
	assign fifoOutReady = 1'b1;

	always @*
	begin
		shiftReg_nxt = shiftReg_r;
		if (fifoOutValid)
			shiftReg_nxt = {shiftReg_r[10:0], fifoOutData}; // R1 R2
	end

	always @*
	begin
		latch_nxt     = latch_r;
		latchPend_nxt = latchPend_r || lckUp;
		if (latchPend_nxt && drainIdle)
		begin
			latch_nxt     = shiftReg_r; // R1 R2 R4
			latchPend_nxt = 1'b0;
		end
	end

	always @(posedge clk or negedge rstSync_r)
	begin
		if (!rstSync_r)
		begin
			shiftReg_r  <= `SSLAT_ZERO12;
			latch_r     <= `SSLAT_ZERO12;
			latchPend_r <= 1'b0;
			lastStage_r <= 1'b0;
		end
		else if (!clrN)
		begin
			shiftReg_r  <= `SSLAT_ZERO12; // R5
			latch_r     <= `SSLAT_ZERO12; // R5
			latchPend_r <= 1'b0;
			lastStage_r <= 1'b0;
		end
		else
		begin
			shiftReg_r  <= shiftReg_nxt;
			latch_r     <= latch_nxt;
			latchPend_r <= latchPend_nxt;
			lastStage_r <= shiftReg_nxt[11]; // R13
		end
	end

	// ==========================================
	// cascade output
	// moved on the fall so the next device samples a settled bit
	always @(posedge clk or negedge rstSync_r)
	begin
		if (!rstSync_r)
			cascadeDataOut <= 1'b0;
		else if (!clrN)
			cascadeDataOut <= 1'b0; // R5
		else if (sckDn)
			cascadeDataOut <= lastStage_r; // R7 R13
	end

	// ==========================================
	// drain output buffers
	// drain bit high means transistor sinking current
	always @(posedge clk or negedge rstSync_r)
	begin
		if (!rstSync_r)
			drainOn <= `SSLAT_ZERO12;
		else if (!clrN)
			drainOn <= `SSLAT_ZERO12; // R3
		else
			drainOn <= gateDrains(latch_nxt, oeN, hot); // R4 R8 R9 R10 R12 R14
	end

	// ==========================================
	// overflow indication
	// follows fifo full; edges push at most every other cycle and the chain takes a bit each cycle, so it never sets
	always @(posedge clk or negedge rstSync_r)
	begin
		if (!rstSync_r)
			shiftStall <= 1'b0;
		else if (!clrN)
			shiftStall <= 1'b0;
		else
			shiftStall <= !fifoInReady; // R1
	end
endmodule
`default_nettype wire

// ==== testbench/sslat_chk.sv ====
// assertions on the driver pins
`default_nettype none
module sslat_chk (
	input wire logic		clk,
	input wire logic		rstn,
	input wire logic		shiftClock,
	input wire logic		latchClock,
	input wire logic		clearN,
	input wire logic		outEnableN,
	input wire logic		overTemp,
	input wire logic		cascadeDataOut,
	input wire logic [11:0]	drainOn,
	input wire logic		shiftStall
);
timeunit 1ns / 100ps;
// ========
// pin relations; windows allow for the 2-ff pin sync
default clocking @(posedge clk); endclocking
default disable iff (!rstn);
oe_off_a: assert property (outEnableN[*6] |-> drainOn == 12'h000)
	else $error("drains on while disabled");
hot_off_a: assert property (overTemp[*6] |-> drainOn == 12'h000)
	else $error("drains on while hot");
clr_hold_a: assert property (!clearN[*6] |-> drainOn == 12'h000)
	else $error("drains on in clear");
clr_fall_a: assert property ($fell(clearN) |->
	##[1:8] (drainOn == 12'h000 && !cascadeDataOut)) else $error("no clear");
drain_hold_a: assert property (
	$stable({latchClock, outEnableN, overTemp, clearN})[*8]
	|=> $stable(drainOn)) else $error("drains moved");
casc_high_a: assert property ((shiftClock && clearN)[*6]
	|-> $stable(cascadeDataOut)) else $error("cascade moved high");
casc_low_a: assert property ((!shiftClock && clearN)[*6]
	|-> $stable(cascadeDataOut)) else $error("cascade moved low");
no_stall_a: assert property (!shiftStall)
	else $error("shift stall");
endmodule
bind sslat_top sslat_chk sslat_chk_inst (.clk(clk), .rstn(rstn),
	.shiftClock(shiftClock), .latchClock(latchClock), .clearN(clearN),
	.outEnableN(outEnableN), .overTemp(overTemp), .drainOn(drainOn),
	.cascadeDataOut(cascadeDataOut), .shiftStall(shiftStall));
`default_nettype wire

// ==== testbench/sslat_host.sv ====
// host model clocking serial frames in
`default_nettype none
module sslat_host (
	output var logic	sck,
	output var logic	lck,
	output var logic	sdi
);
timeunit 1ns / 100ps;
// ========
// frame sender; link clock stands low between frames
initial {sck, lck, sdi} = 3'h0;
task automatic frame(input logic [11:0] w);
	for (int i = 11; i >= 0; i--)
	begin
		sdi = w[i];
		#62.5 sck = 1'b1;
		#62.5 sck = 1'b0;
	end
	sdi = ~sdi;
	#62.5 lck = 1'b1;
	#62.5 lck = 1'b0;
endtask
task automatic latch_only;
	#62.5 lck = 1'b1;
	#62.5 lck = 1'b0;
endtask
endmodule
`default_nettype wire

// ==== testbench/sslat_top_tb.sv ====
// self-checking bench for the shift latch driver
`default_nettype none
module sslat_top_tb;
timeunit 1ns / 100ps;
logic clk = 0, rstn = 0, clearN = 0, outEnableN = 0, overTemp = 0;
wire sck, lck, sdi, cascadeDataOut, shiftStall;
wire [11:0] drainOn;
int numErrors = 0, checkCount = 0;
always #4 clk = ~clk;
sslat_host sslat_host_inst (.sck(sck), .lck(lck), .sdi(sdi));
sslat_top sslat_top_inst (.clk(clk), .rstn(rstn), .shiftClock(sck),
	.latchClock(lck), .clearN(clearN), .shiftDataIn(sdi),
	.outEnableN(outEnableN), .overTemp(overTemp), .drainOn(drainOn),
	.cascadeDataOut(cascadeDataOut), .shiftStall(shiftStall));
// ========
// shared tasks
task conclude;
	$display("checks %0d errors %0d", checkCount, numErrors);
	if (numErrors == 0 && checkCount > 0)
		$display("TEST PASSED");
	else
		$display("TEST FAILED");
	$finish;
endtask
task chk(input logic [11:0] seen, input logic [11:0] want);
	checkCount++;
	if (seen !== want)
	begin
		numErrors++;
		$display("unexpected %0t saw %h want %h", $time, seen, want);
	end
endtask
task settle;
	repeat (12) @(posedge clk);
endtask
// ========
// scenarios
task load_word(input logic [11:0] w);
	sslat_host_inst.frame(w);
	settle;
	chk(drainOn, w);
	chk({11'h000, cascadeDataOut}, {11'h000, w[11]});
	chk({11'h000, shiftStall}, 12'h000);
endtask
task pwm_dim;
	for (int i = 0; i < 3; i++)
	begin
		@(posedge clk) outEnableN <= 1'b1;
		settle;
		chk(drainOn, 12'h000);
		@(posedge clk) outEnableN <= 1'b0;
		settle;
		chk(drainOn, 12'ha5c);
	end
endtask
task hot_trip;
	@(posedge clk) overTemp <= 1'b1;
	settle;
	chk(drainOn, 12'h000);
	@(posedge clk) overTemp <= 1'b0;
	settle;
	chk(drainOn, 12'ha5c);
endtask
task clear_all;
	@(posedge clk) clearN <= 1'b0;
	settle;
	chk(drainOn, 12'h000);
	chk({11'h000, cascadeDataOut}, 12'h000);
	@(posedge clk) clearN <= 1'b1;
	settle;
	sslat_host_inst.latch_only;
	settle;
	chk(drainOn, 12'h000);
endtask
// ========
// main sequence; clear held low through start-up
initial
begin
	repeat (3) @(posedge clk);
	rstn <= 1'b1;
	repeat (4) @(posedge clk);
	clearN <= 1'b1;
	load_word(12'h3f1);
	load_word(12'ha5c);
	pwm_dim;
	hot_trip;
	clear_all;
	conclude;
end
initial
begin
	#200us;
	numErrors++;
	conclude;
end
endmodule
`default_nettype wire
